// ### logic/global_command_and_id_regs.sv
// Purpose: Global command register, interrupt summary, mask and id registers of two halves
// Assumes: A decoded register port (strobe, offset, A0, data) from the serial front end
// Notes:   Actions leave as one-cycle pulses; i_ce low freezes all state
`timescale 1ns/1ps
`include "pse_consts.svh"
// Function
// - Command register at 0x0B is write-only; reads return zero.
// - Command bit 7 clears the addressed interrupt summary register.
// - Command bit 6 releases the addressed half's interrupt pin latch, keeping all event flags.
// - Command bit 5 powers off every powered low-priority port.
// - Command bit 4 resets ports and registers of the A0-selected half.
// - Software reset leaves the shared configuration register unchanged.
// - Software reset never resets the controller core; only the reset pin does.
// - Command bit 1 puts all ports of the selected half into shutdown.
// - Command bit 0 turns off all ports of the selected half normally.
// - Registers 0x0C to 0x0E are read-only; writes are ignored.
// - 0x0C returns fixed part code and silicon revision nibbles.
// - 0x0D returns firmware revision as decimal major and minor nibbles.
// - 0x0E returns fixed maker code and device version nibbles.
// - Interrupt pin asserts only for events whose mask bit at 0x01 is set.
module global_command_and_id_regs #(
  parameter logic [3:0] PART_CODE = 4'h9, // Arbitrary value
  parameter logic [3:0] SI_REV    = 4'h3, // Arbitrary value
  parameter logic [7:0] FW_REV    = 8'h12,
  parameter logic [3:0] MAKER     = 4'h7, // Arbitrary value
  parameter logic [3:0] DEV_VER   = 4'h5  // Arbitrary value
) (
  input  wire logic           i_mclk,
  input  wire logic           i_nrst,
  input  wire logic           i_ce,
  input  wire logic           i_a0,
  input  wire logic           i_wr_stb,
  input  wire logic           i_rd_stb,
  input  wire pse_pkg::byte_t i_addr,
  input  wire pse_pkg::byte_t i_wdata,
  output pse_pkg::byte_t      o_rdata,
  input  wire pse_pkg::byte_t i_port_evt,
  input  wire pse_pkg::kinds_t i_evt_kind,
  input  wire pse_pkg::byte_t i_port_on,
  input  wire pse_pkg::byte_t i_port_lowpri,
  output logic                o_int_n,
  output logic [1:0]          o_half_rst,
  output logic [1:0]          o_half_shut,
  output logic [1:0]          o_half_off,
  output pse_pkg::byte_t      o_shed,
  output pse_pkg::byte_t      o_config
);
  import pse_pkg::*;

  localparam regs_t REGS_RST = '{
    summ:  `SUMM_RST,
    mask:  {`MASK_RST, `MASK_RST},
    pin:   2'b00,
    cfg:   `CFG_RST,
    rdata: `RDATA_RST,
    shed:  8'h00
  };

  regs_t      s_r;
  regs_t      s_nxt;
  logic       cmd_wr;
  logic       mask_wr;
  logic       cfg_wr;
  logic [1:0] kind_hit;
  byte_t      shed_cand;
  byte_t      rd_mux;

  cmd_if cmd ();

  assign cmd_wr    = i_wr_stb && (i_addr == `ADDR_CMD);
  assign mask_wr   = i_wr_stb && (i_addr == `ADDR_MASK);
  assign cfg_wr    = i_wr_stb && (i_addr == `ADDR_CFG);
  assign shed_cand = i_port_on & i_port_lowpri;

  assign cmd.stb  = cmd_wr && i_ce;
  assign cmd.a0   = i_a0;
  assign cmd.data = i_wdata;

  for (genvar g = 0; g < 2; g++) begin : g_half
    assign kind_hit[g] = |(i_evt_kind[g] & s_r.mask[g]);
    half_ctrl #(.HALF(1'(g))) u_half (
      .i_mclk (i_mclk),
      .i_nrst (i_nrst),
      .i_ce   (i_ce),
      .cmd    (cmd),
      .o_rst  (o_half_rst[g]),
      .o_shut (o_half_shut[g]),
      .o_off  (o_half_off[g])
    );
  end

  always_comb begin
    unique case (i_addr)
      `ADDR_INT:   rd_mux = {4'h0, (i_a0 ? s_r.summ[7:4] : s_r.summ[3:0])};
      `ADDR_MASK:  rd_mux = s_r.mask[i_a0];
      `ADDR_CFG:   rd_mux = s_r.cfg;
      `ADDR_PART:  rd_mux = {PART_CODE, SI_REV};
      `ADDR_FW:    rd_mux = FW_REV;
      `ADDR_MAKER: rd_mux = {MAKER, DEV_VER};
      default:     rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    s_nxt      = s_r;
    s_nxt.shed = 8'h00;
    if (cmd_wr && i_wdata[`CMD_LOWPRI]) begin
      s_nxt.shed = shed_cand;
    end
    for (int h = 0; h < 2; h++) begin
      // Half reset restores its own registers; the pulse is one cycle after the write
      if (o_half_rst[h]) begin
        s_nxt.summ[h*4 +: 4] = 4'h0;
        s_nxt.mask[h]        = `MASK_RST;
        s_nxt.pin[h]         = 1'b0;
      end
      if (mask_wr && (i_a0 == h[0])) begin
        s_nxt.mask[h] = i_wdata;
      end
      if (cmd_wr && (i_a0 == h[0]) && i_wdata[`CMD_INTCLR]) begin
        s_nxt.summ[h*4 +: 4] = 4'h0;
      end
      if (cmd_wr && (i_a0 == h[0]) && i_wdata[`CMD_PINCLR]) begin
        s_nxt.pin[h] = 1'b0;
      end
      // Set wins over any clear in the same cycle
      s_nxt.summ[h*4 +: 4] = s_nxt.summ[h*4 +: 4] | i_port_evt[h*4 +: 4];
      if (kind_hit[h]) begin
        s_nxt.pin[h] = 1'b1;
      end
    end
    // Shared configuration is untouched by half resets
    if (cfg_wr) begin
      s_nxt.cfg = i_wdata;
    end
    // Id offsets have no write path at all
    if (i_rd_stb) begin
      s_nxt.rdata = rd_mux;
    end
  end

  // Only the reset pin brings the whole bank, shared state included, to defaults
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_r <= REGS_RST;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  assign o_rdata  = s_r.rdata;
  assign o_shed   = s_r.shed;
  assign o_config = s_r.cfg;
  assign o_int_n  = !(s_r.cfg[`CFG_INTEN] && (|s_r.pin));

  a_cmd_reads_zero: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_ce && i_rd_stb && (i_addr == `ADDR_CMD)) |=> (o_rdata == 8'h00))
    else $error("command register read not zero");

  a_intclr_clears: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_ce && cmd_wr && !i_a0 && i_wdata[`CMD_INTCLR] && (i_port_evt[3:0] == 4'h0))
    |=> (s_r.summ[3:0] == 4'h0))
    else $error("summary not cleared");

  a_pinclr_drops: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_ce && cmd_wr && i_wdata[`CMD_PINCLR] && !kind_hit[i_a0])
    |=> !s_r.pin[$past(i_a0)])
    else $error("pin latch not released");

  a_pinclr_keeps: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_ce && cmd_wr && i_wdata[`CMD_PINCLR] && !i_wdata[`CMD_INTCLR] && (o_half_rst == 2'b00))
    |=> ((s_r.summ & $past(s_r.summ)) == $past(s_r.summ)))
    else $error("pin release changed event flags");

  a_shed_lowpri: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_ce && cmd_wr && i_wdata[`CMD_LOWPRI]) |=> (o_shed == $past(shed_cand)) ##1 (o_shed == 8'h00
      || $past(i_ce) == 1'b0 || $past(cmd_wr)))
    else $error("low priority shed wrong");

  a_cfg_kept: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_ce && (o_half_rst != 2'b00) && !cfg_wr) |=> $stable(o_config))
    else $error("config changed by half reset");

  a_id_readonly: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_ce && i_wr_stb && (i_addr >= `ADDR_PART) && (i_addr <= `ADDR_MAKER)
      && (o_half_rst == 2'b00)) |=> ($stable(s_r.mask) && $stable(s_r.cfg)))
    else $error("write to id register changed state");

  a_part_read: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_ce && i_rd_stb && (i_addr == `ADDR_PART)) |=> (o_rdata == {PART_CODE, SI_REV}))
    else $error("part register wrong");

  a_fw_read: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_ce && i_rd_stb && (i_addr == `ADDR_FW)) |=> (o_rdata == FW_REV))
    else $error("firmware register wrong");

  a_maker_read: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_ce && i_rd_stb && (i_addr == `ADDR_MAKER)) |=> (o_rdata == {MAKER, DEV_VER}))
    else $error("maker register wrong");

  a_pin_masked: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    $rose(s_r.pin[0]) |-> $past(kind_hit[0]))
    else $error("pin set without masked event");

  a_half_shut: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_ce && cmd_wr && i_a0 && i_wdata[`CMD_RSTALL]) |=> (o_half_shut == 2'b10))
    else $error("shutdown went to wrong half");

  a_half_off: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_ce && cmd_wr && !i_a0 && i_wdata[`CMD_OFFALL]) |=> (o_half_off == 2'b01))
    else $error("power off went to wrong half");

  // Half reset restores half 1's mask unless the host rewrites that mask in the same cycle
  a_half_rst_mask: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_ce && o_half_rst[1] && !(mask_wr && i_a0)) |=> (s_r.mask[1] == `MASK_RST))
    else $error("half reset left mask set");

  a_half_rst_summ: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_ce && o_half_rst[1] && (i_port_evt[7:4] == 4'h0)) |=> (s_r.summ[7:4] == 4'h0))
    else $error("half reset left summary set");

  // Shed is a one-shot: without a written one it stays at zero
  a_shed_idle: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_ce && !(cmd_wr && i_wdata[`CMD_LOWPRI])) |=> (o_shed == 8'h00))
    else $error("shed pulse without command");

endmodule

// ### logic/pse_consts.svh
// Purpose: Offsets, field positions and reset values of the global command and id registers
// Assumes: Byte-wide registers addressed by an 8-bit offset
// Notes:   Included by the design modules
`ifndef PSE_CONSTS_SVH
`define PSE_CONSTS_SVH

`define ADDR_INT     8'h00
`define ADDR_MASK    8'h01
`define ADDR_CFG     8'h0a
`define ADDR_CMD     8'h0b
`define ADDR_PART    8'h0c
`define ADDR_FW      8'h0d
`define ADDR_MAKER   8'h0e

`define CMD_INTCLR   7
`define CMD_PINCLR   6
`define CMD_LOWPRI   5
`define CMD_SWRST    4
`define CMD_RSTALL   1
`define CMD_OFFALL   0

`define CFG_INTEN    7

`define SUMM_RST     8'h00
`define MASK_RST     8'h00
`define CFG_RST      8'h80
`define RDATA_RST    8'h00

`endif

// ### logic/pse_pkg.sv
// Purpose: Types shared by the command and id register bank
// Assumes: Two four-port halves
// Notes:   Offsets and values live in pse_consts.svh
package pse_pkg;

  typedef logic [7:0]      byte_t;
  typedef logic [1:0][7:0] kinds_t;

  typedef struct packed {
    logic [7:0]      summ;
    logic [1:0][7:0] mask;
    logic [1:0]      pin;
    logic [7:0]      cfg;
    logic [7:0]      rdata;
    logic [7:0]      shed;
  } regs_t;

  typedef struct packed {
    logic rst;
    logic shut;
    logic off;
  } half_t;

endpackage

// ### logic/cmd_if.sv
// Purpose: Carries accepted command writes from the register bank to each half
// Assumes: stb is high for one enabled cycle per accepted write
// Notes:   a0 selects the half that the write addresses
`timescale 1ns/1ps
interface cmd_if;
  logic       stb;
  logic       a0;
  logic [7:0] data;

  modport src (output stb, output a0, output data);
  modport dst (input stb, input a0, input data);
endinterface

// ### logic/half_ctrl.sv
// Purpose: Turns command writes into one-cycle actions for one four-port half
// Assumes: Commands arrive on cmd_if; i_ce freezes state
// Notes:   Instantiated once per half
`timescale 1ns/1ps
`include "pse_consts.svh"
module half_ctrl #(
  parameter bit HALF = 1'b0
) (
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  cmd_if.dst        cmd,
  output logic      o_rst,
  output logic      o_shut,
  output logic      o_off
);
  import pse_pkg::*;

  half_t s_r;
  half_t s_nxt;
  logic  hit;

  assign hit = cmd.stb && (cmd.a0 == HALF);

  always_comb begin
    s_nxt      = '0;
    // Each bit is its own one-shot, several may fire together; bits 3:2 do nothing
    s_nxt.rst  = hit && cmd.data[`CMD_SWRST];
    s_nxt.shut = hit && cmd.data[`CMD_RSTALL];
    s_nxt.off  = hit && cmd.data[`CMD_OFFALL];
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_r <= '0;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  assign o_rst  = s_r.rst;
  assign o_shut = s_r.shut;
  assign o_off  = s_r.off;

  a_swrst_fires: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_ce && hit && cmd.data[`CMD_SWRST]) |=> o_rst)
    else $error("software reset pulse missing");

  a_rsvd_inert: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_ce && cmd.stb && (cmd.data[1:0] == 2'b00) && (cmd.data[4] == 1'b0))
    |=> (!o_rst && !o_shut && !o_off))
    else $error("action without its command bit");

  a_multi_cmd: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_ce && hit && cmd.data[`CMD_RSTALL] && cmd.data[`CMD_OFFALL]) |=> (o_shut && o_off))
    else $error("combined command lost an action");

endmodule

// ### verif/host_port_model.sv
// Purpose: Host side of the decoded register port, one access per call
// Assumes: Strobes are taken on the rising edge; read data is valid one cycle later
// Notes:   Released address and data lines show the inverse of their last value
`timescale 1ns/1ps
module host_port_model (
  input  wire logic           i_mclk,
  input  wire pse_pkg::byte_t i_rdata,
  output logic                o_a0,
  output logic                o_wr_stb,
  output logic                o_rd_stb,
  output pse_pkg::byte_t      o_addr,
  output pse_pkg::byte_t      o_wdata
);
  import pse_pkg::*;
  initial begin
    o_a0     = 1'b0;
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
    o_addr   = 8'h00;
    o_wdata  = 8'h00;
  end
  // Returns 1 ns after the taking edge, where pulses and read data show
  task automatic acc(input logic wr, input logic a0, input byte_t addr, input byte_t wd,
                     output byte_t rd);
    @(posedge i_mclk);
    o_a0     <= a0;
    o_addr   <= addr;
    o_wdata  <= wd;
    o_wr_stb <= wr;
    o_rd_stb <= ~wr;
    @(posedge i_mclk);
    o_wr_stb <= 1'b0;
    o_rd_stb <= 1'b0;
    o_addr   <= ~addr;
    o_wdata  <= ~wd;
    #1;
    rd = i_rdata;
  endtask
endmodule

// ### verif/global_command_and_id_regs_tb_top.sv
// Purpose: Self-checking bench for the command and id register bank
// Assumes: One 40 MHz clock; the host model drives the register port
// Notes:   Row table first, then shed, interrupt, soft reset and enable cases
`timescale 1ns/1ps
module global_command_and_id_regs_tb_top;
  import pse_pkg::*;
  typedef struct packed {
    logic  wr;
    logic  a0;
    byte_t addr;
    byte_t wd;
    byte_t exp;
  } row_t;
  logic       i_mclk        = 1'b0;
  logic       i_nrst        = 1'b0;
  logic       i_ce          = 1'b1;
  byte_t      i_port_evt    = 8'h00;
  kinds_t     i_evt_kind    = '0;
  byte_t      i_port_on     = 8'hf3;
  byte_t      i_port_lowpri = 8'h5c;
  logic       a0;
  logic       wr_stb;
  logic       rd_stb;
  byte_t      addr;
  byte_t      wdata;
  byte_t      o_rdata;
  byte_t      o_shed;
  byte_t      o_config;
  byte_t      rd;
  logic       o_int_n;
  logic [1:0] o_half_rst;
  logic [1:0] o_half_shut;
  logic [1:0] o_half_off;
  int         n_mismatch    = 0;
  int         checks        = 0;
  row_t       rows [12];

  always #12.5 i_mclk = ~i_mclk;

  global_command_and_id_regs uut (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(i_ce), .i_a0(a0), .i_wr_stb(wr_stb),
    .i_rd_stb(rd_stb), .i_addr(addr), .i_wdata(wdata), .o_rdata(o_rdata),
    .i_port_evt(i_port_evt), .i_evt_kind(i_evt_kind), .i_port_on(i_port_on),
    .i_port_lowpri(i_port_lowpri), .o_int_n(o_int_n), .o_half_rst(o_half_rst),
    .o_half_shut(o_half_shut), .o_half_off(o_half_off), .o_shed(o_shed),
    .o_config(o_config)
  );

  host_port_model host (
    .i_mclk(i_mclk), .i_rdata(o_rdata), .o_a0(a0), .o_wr_stb(wr_stb),
    .o_rd_stb(rd_stb), .o_addr(addr), .o_wdata(wdata)
  );

  task automatic chk(input byte_t got, input byte_t exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic evt(input byte_t port, input byte_t kind);
    @(posedge i_mclk);
    i_port_evt    <= port;
    i_evt_kind[0] <= kind;
    @(posedge i_mclk);
    i_port_evt    <= 8'h00;
    i_evt_kind    <= '0;
    #1;
  endtask

  task automatic end_of_test;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #75000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    // Writes expect {2'b00, rst, shut, off}; reads expect the data
    rows[0]  = '{1'b0, 1'b0, 8'h0c, 8'h00, 8'h93};
    rows[1]  = '{1'b0, 1'b1, 8'h0d, 8'h00, 8'h12};
    rows[2]  = '{1'b0, 1'b0, 8'h0e, 8'h00, 8'h75};
    rows[3]  = '{1'b0, 1'b0, 8'h0b, 8'h00, 8'h00};
    rows[4]  = '{1'b1, 1'b1, 8'h0b, 8'h13, 8'h2a};
    rows[5]  = '{1'b1, 1'b0, 8'h0b, 8'h01, 8'h01};
    rows[6]  = '{1'b1, 1'b0, 8'h0b, 8'h02, 8'h04};
    rows[7]  = '{1'b1, 1'b0, 8'h0b, 8'h10, 8'h10};
    rows[8]  = '{1'b1, 1'b0, 8'h0b, 8'h0c, 8'h00};
    rows[9]  = '{1'b1, 1'b0, 8'h0c, 8'hff, 8'h00};
    rows[10] = '{1'b0, 1'b0, 8'h0c, 8'h00, 8'h93};
    rows[11] = '{1'b0, 1'b0, 8'h55, 8'h00, 8'h00};
    repeat (3) @(posedge i_mclk);
    i_nrst <= 1'b1;
    #1;
    chk({7'h00, o_int_n}, 8'h01);
    foreach (rows[i]) begin
      host.acc(rows[i].wr, rows[i].a0, rows[i].addr, rows[i].wd, rd);
      chk(rows[i].wr ? {2'b00, o_half_rst, o_half_shut, o_half_off} : rd, rows[i].exp);
    end
    host.acc(1'b1, 1'b1, 8'h0b, 8'h20, rd);
    chk(o_shed, 8'h50);
    @(posedge i_mclk);
    #1;
    chk(o_shed, 8'h00);
    host.acc(1'b1, 1'b0, 8'h01, 8'h02, rd);
    evt(8'h00, 8'h01);
    chk({7'h00, o_int_n}, 8'h01);
    evt(8'h01, 8'h02);
    chk({7'h00, o_int_n}, 8'h00);
    host.acc(1'b1, 1'b0, 8'h0b, 8'h40, rd);
    chk({7'h00, o_int_n}, 8'h01);
    host.acc(1'b0, 1'b0, 8'h00, 8'h00, rd);
    chk(rd, 8'h01);
    host.acc(1'b1, 1'b0, 8'h0b, 8'h80, rd);
    host.acc(1'b0, 1'b0, 8'h00, 8'h00, rd);
    chk(rd, 8'h00);
    host.acc(1'b1, 1'b1, 8'h01, 8'hff, rd);
    host.acc(1'b1, 1'b0, 8'h0a, 8'h3c, rd);
    host.acc(1'b1, 1'b1, 8'h0b, 8'h10, rd);
    @(posedge i_mclk);
    #1;
    chk(o_config, 8'h3c);
    host.acc(1'b0, 1'b1, 8'h01, 8'h00, rd);
    chk(rd, 8'h00);
    host.acc(1'b0, 1'b0, 8'h01, 8'h00, rd);
    chk(rd, 8'h02);
    @(posedge i_mclk);
    i_ce <= 1'b0;
    host.acc(1'b1, 1'b0, 8'h0b, 8'h13, rd);
    chk({2'b00, o_half_rst, o_half_shut, o_half_off}, 8'h00);
    @(posedge i_mclk);
    i_ce   <= 1'b1;
    i_nrst <= 1'b0;
    @(posedge i_mclk);
    i_nrst <= 1'b1;
    #1;
    chk(o_config, 8'h80);
    end_of_test();
  end
endmodule
